/* tb/rsfdc_master_model.sv */
// Purpose: Serial bus master model facing the RTU slave decoder
// Assumes: One byte per RX_VALID pulse; reply bytes taken on TX_VALID and TX_READY
// Notes: slow toggles TX_READY so the reply path sees stalls
`timescale 1ns/1ns
`default_nettype none
module rsfdc_master_model (
  input  wire logic       CLK,
  output var  logic       RX_VALID,
  output var  logic [7:0] RX_BYTE,
  output var  logic       RX_ERR,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_BYTE,
  output var  logic       TX_READY
);
  bit         slow = 1'b0;
  logic [7:0] txq[$];

  initial begin
    RX_VALID = 1'b0;
    RX_BYTE  = 8'h00;
    RX_ERR   = 1'b0;
    TX_READY = 1'b0;
  end

  //////////////////////////////
  // Reflected CRC-16, also used to judge the slave's replies
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Line shows the inverted byte when idle, so a stale value never looks valid
  task automatic send(input logic [7:0] f[$], input bit bad, input int err_at, input int spc);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_BYTE  <= f[i];
      RX_ERR   <= (i == err_at);
      @(posedge CLK);
      RX_VALID <= 1'b0;
      RX_BYTE  <= ~f[i];
      RX_ERR   <= 1'b0;
      repeat (spc) @(posedge CLK);
    end
  endtask

  //////////////////////////////
  always @(posedge CLK) begin
    TX_READY <= slow ? ~TX_READY : 1'b1;
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) txq.push_back(TX_BYTE);
  end
endmodule // rsfdc_master_model
`default_nettype wire

/* tb/tb_rtu_slave_function_decode_crc.sv */
// Purpose: Self-checking bench for the RTU slave decoder
// Assumes: GAP_CYCLES cut to 20 so each frame costs under two hundred cycles
// Notes: Replies are judged with the model's own CRC, never the DUT's
`timescale 1ns/1ns
`default_nettype none
module tb_rtu_slave_function_decode_crc;
  localparam int GAP = 20;
  logic                  CLK = 1'b0;
  logic                  RST_N = 1'b0;
  logic [7:0]            STATION = 8'h05;
  logic [4:0]            DATA_IDX = 5'h00;
  logic                  TX_IN_VALID = 1'b0;
  logic [7:0]            TX_IN_BYTE = 8'h00;
  logic                  TX_IN_LAST = 1'b0;
  logic                  RX_VALID, RX_ERR, TX_READY, REQ_VALID, FRAME_DROP, TX_IN_READY, TX_VALID;
  logic [7:0]            RX_BYTE, TX_BYTE;
  logic [15:0]           DATA_WORD;
  rsfdc_pkg::rsfdc_req_t REQ;
  int                    mismatches = 0, comparisons = 0, cyc = 0, t_last = 0, t_ev = 0;
  int                    n_req = 0, n_drop = 0;

  always #5 CLK = ~CLK;

  rsfdc_slave #(.GAP_CYCLES(GAP)) dut_u (.CLK(CLK), .RST_N(RST_N), .RX_VALID(RX_VALID),
    .RX_BYTE(RX_BYTE), .RX_ERR(RX_ERR), .STATION(STATION), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .FRAME_DROP(FRAME_DROP), .DATA_IDX(DATA_IDX), .DATA_WORD(DATA_WORD),
    .TX_IN_VALID(TX_IN_VALID), .TX_IN_BYTE(TX_IN_BYTE), .TX_IN_LAST(TX_IN_LAST),
    .TX_IN_READY(TX_IN_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY));
  rsfdc_master_model master_u (.CLK(CLK), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
    .RX_ERR(RX_ERR), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY));

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (RX_VALID === 1'b1) t_last <= cyc;
    if (REQ_VALID === 1'b1) n_req <= n_req + 1;
    if (FRAME_DROP === 1'b1) n_drop <= n_drop + 1;
    if (REQ_VALID === 1'b1 || FRAME_DROP === 1'b1) t_ev <= cyc;
  end

  //////////////////////////////
  // Wide enough for the largest packed group of request fields judged at once
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic add_crc(inout logic [7:0] q[$]);
    logic [15:0] c;
    c = master_u.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask

  // One frame in, optional reply body, then the whole reply and pulse counts judged
  task automatic run(input logic [7:0] f[$], input logic [7:0] body[$], input logic [7:0] e[$],
                     input int spc, input int err_at, input bit bad, input int er, input int ed);
    int r0;
    int d0;
    int k;
    r0 = n_req;
    d0 = n_drop;
    master_u.txq.delete();
    master_u.send(f, bad, err_at, spc);
    k = 0;
    while (n_req == r0 && n_drop == d0 && k < GAP + 12) begin
      @(posedge CLK);
      k++;
    end
    if (er + ed > 0) check((t_ev - t_last) inside {[GAP + 1:GAP + 3]}, 1'b1);
    foreach (body[i]) begin
      TX_IN_VALID <= 1'b1;
      TX_IN_BYTE  <= body[i];
      TX_IN_LAST  <= (i == body.size() - 1);
      k = 0;
      do begin
        @(posedge CLK);
        k++;
      end while (TX_IN_READY !== 1'b1 && k < 300);
    end
    TX_IN_VALID <= 1'b0;
    TX_IN_BYTE  <= ~TX_IN_BYTE;
    k = 0;
    while (master_u.txq.size() < e.size() && k < 400) begin
      @(posedge CLK);
      k++;
    end
    // Silence long enough to prove no late bytes and to end the frame gap
    repeat (GAP + 8) @(posedge CLK);
    check(n_req - r0, er);
    check(n_drop - d0, ed);
    check(master_u.txq.size(), e.size());
    foreach (e[i]) check(master_u.txq[i], e[i]);
  endtask

  //////////////////////////////
  task automatic t_unicast();
    logic [7:0] f[$];
    logic [7:0] e[$];
    check(master_u.crc16('{8'h11, 8'h03, 8'h03, 8'heb, 8'h00, 8'h03}), 16'h2b77);
    @(posedge CLK);
    STATION <= 8'h11;
    master_u.slow = 1'b1;
    run('{8'h11, 8'h03, 8'h03, 8'heb, 8'h00, 8'h03}, '{8'h06, 8'h17, 8'h70, 8'h0b, 8'hb8,
        8'h03, 8'he8}, '{8'h11, 8'h03, 8'h06, 8'h17, 8'h70, 8'h0b, 8'hb8, 8'h03, 8'he8,
        8'h2c, 8'he6}, 1, -1, 0, 1, 0);
    check({REQ.addr, REQ.func, REQ.bcast, REQ.reg_addr, REQ.word},
          {8'h11, 8'h03, 1'b0, 32'h03eb0003});
    master_u.slow = 1'b0;
    STATION <= 8'h05;
    f = '{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70};
    run(f, f[2:5], '{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70, 8'h17, 8'h99}, GAP - 6, -1, 0,
        1, 0);
    check({REQ.func, REQ.reg_addr, REQ.word}, {8'h06, 32'h000d1770});
    f = '{8'h05, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    e = f;
    add_crc(e);
    run(f, f[2:5], e, 1, -1, 0, 1, 0);
    check(REQ.func, 8'h08);
    e = '{8'h05, 8'h46, 8'h07};
    add_crc(e);
    run(e[0:1], e[2:2], e, 1, -1, 0, 1, 0);
    check(REQ.func, 8'h46);
    f = '{8'h05, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'hab, 8'hcd, 8'h12, 8'h34};
    e = f[0:5];
    add_crc(e);
    run(f, f[2:5], e, 1, -1, 0, 1, 0);
    check({REQ.func, REQ.byte_cnt, REQ.word, DATA_WORD}, {16'h1004, 32'h0002abcd});
    DATA_IDX <= 5'h01;
    repeat (2) @(posedge CLK);
    check(DATA_WORD, 16'h1234);
    $display("done unicast functions");
  endtask

  task automatic t_broadcast();
    logic [7:0] n[$];
    run('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, n, n, 1, -1, 0, 1, 0);
    check({REQ.addr, REQ.func, REQ.bcast}, {8'h00, 8'h06, 1'b1});
    run('{8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd}, n, n, 1, -1, 0, 1, 0);
    check({REQ.func, REQ.bcast}, {8'h10, 1'b1});
    run('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, n, n, 1, -1, 0, 0, 1);
    run('{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, n, n, 1, -1, 0, 0, 1);
    run('{8'h00, 8'h46}, n, n, 1, -1, 0, 0, 1);
    $display("done broadcast");
  endtask

  task automatic t_faults();
    logic [7:0] n[$];
    logic [7:0] e[$];
    run('{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70}, n, n, 1, -1, 1, 0, 1);
    run('{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70}, n, n, 1, 2, 0, 0, 1);
    // Foreign station number: dropped, no request and no reply
    run('{8'h09, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70}, n, n, 1, -1, 0, 0, 1);
    e = '{8'h05, 8'h87, 8'h01};
    add_crc(e);
    run('{8'h05, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, n, e, 1, -1, 0, 0, 0);
    e = '{8'h05, 8'h83, 8'h03};
    add_crc(e);
    run('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, n, e, 1, -1, 0, 0, 0);
    $display("done faults and exceptions");
  endtask

  //////////////////////////////
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    check({REQ_VALID, FRAME_DROP, TX_VALID, TX_IN_READY, TX_BYTE}, 12'h000);
    t_unicast();
    t_broadcast();
    t_faults();
    finish_test();
  end

  // About 15 frames of up to about two hundred cycles each; generous margin
  initial begin
    repeat (30000) @(posedge CLK);
    mismatches++;
    finish_test();
  end
endmodule // tb_rtu_slave_function_decode_crc
`default_nettype wire

/* verilog/rsfdc_pkg.sv */
// Purpose: Constants, request carrier and CRC step for the RTU slave decoder
// Assumes: 100 MHz clock, byte stream from a UART that flags its own errors
// Notes on behaviour
// [R1] Code 03 reads holding registers and is never taken from a broadcast.
// [R2] Code 06 writes one holding register and is executed from a broadcast too.
// [R3] Code 08 is a communication check and is never taken from a broadcast.
// [R4] Code 10 writes consecutive holding registers and is executed from a broadcast too.
// [R5] Code 46 returns the last access count and is never taken from a broadcast.
// [R6] The data field is parsed by function code into counts, addresses and values.
// [R7] Every sent frame ends in a two-byte CRC, low byte first, then high byte.
// [R8] The CRC is recomputed while bytes arrive and any mismatch marks the frame bad.
// [R9] An unsupported code or illegal data is answered with the code plus 80h and an error code.
// [R10] A frame with a CRC, framing or reception error gets no reply at all.
// [R11] Frames are bounded by at least 3.5 character times of line silence.
// [R12] Address 0 is executed whatever the station number and never answered.
// [R13] The CRC is CRC-16 with reflected polynomial A001h, preset FFFFh, LSB first.
// [R14] A broadcast carrying a code not allowed for broadcast is dropped silently.
`default_nettype none
package rsfdc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // One 11-bit character at 9600 baud; adjust for other line rates
  localparam int CHAR_TIME_NS  = 1146000;
  localparam int GAP_TENTHS    = 35;
  localparam int GAP_NS        = CHAR_TIME_NS / 10 * GAP_TENTHS;
  localparam int GAP_CYCLES    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0]  FC_READ      = 8'h03;
  localparam logic [7:0]  FC_WRITE1    = 8'h06;
  localparam logic [7:0]  FC_DIAG      = 8'h08;
  localparam logic [7:0]  FC_WRITEN    = 8'h10;
  localparam logic [7:0]  FC_LOG       = 8'h46;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  ERR_ILL_FUNC = 8'h01;
  localparam logic [7:0]  ERR_ILL_DATA = 8'h03;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;

  localparam int          BUF_DEPTH    = 64;
  localparam logic [7:0]  LEN_MIN      = 8'h04;
  localparam logic [7:0]  LEN_FIXED    = 8'h08;
  localparam logic [7:0]  LEN_LOG      = 8'h04;
  localparam logic [8:0]  LEN_MULTI_HDR = 9'h009;
  localparam logic [7:0]  LEN_BUF_MAX  = 8'h40;
  localparam logic [15:0] MAX_READ_QTY = 16'h007d;
  localparam logic [6:0]  MULTI_DATA_AT = 7'h07;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic        bcast;
    logic [15:0] reg_addr;
    logic [15:0] word;
    logic [7:0]  byte_cnt;
  } rsfdc_req_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1); // [R13]
    end
    return c;
  endfunction
endpackage
`default_nettype wire

/* verilog/rsfdc_slave.sv */
// Purpose: RTU slave frame receiver, function decoder and reply framer
// Assumes: RX bytes arrive one per RX_VALID pulse; TX_READY from the UART
// Notes: Frames longer than 64 bytes are cut; holding store gets REQ and answers via TX_IN_BYTE
`timescale 1ns/1ns
`default_nettype none
module rsfdc_slave #(
  parameter int GAP_CYCLES = rsfdc_pkg::GAP_CYCLES
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  RX_VALID,
  input  wire logic [7:0]            RX_BYTE,
  input  wire logic                  RX_ERR,
  input  wire logic [7:0]            STATION,
  output var  logic                  REQ_VALID,
  output var  rsfdc_pkg::rsfdc_req_t REQ,
  output var  logic                  FRAME_DROP,
  input  wire logic [4:0]            DATA_IDX,
  output var  logic [15:0]           DATA_WORD,
  input  wire logic                  TX_IN_VALID,
  input  wire logic [7:0]            TX_IN_BYTE,
  input  wire logic                  TX_IN_LAST,
  output var  logic                  TX_IN_READY,
  output var  logic                  TX_VALID,
  output var  logic [7:0]            TX_BYTE,
  input  wire logic                  TX_READY
);
  typedef enum logic [3:0] {
    S_IDLE, S_RECV, S_CHECK, S_ADDR, S_FUNC, S_BODY, S_EXC, S_CRCL, S_CRCH
  } rsfdc_state_t;

  rsfdc_state_t state_reg;
  logic [7:0]   buf_mem [rsfdc_pkg::BUF_DEPTH];
  logic [7:0]   len_reg;
  logic         err_reg;
  logic [15:0]  rx_crc_reg;
  logic [15:0]  tx_crc_reg;
  logic [31:0]  gap_reg;
  logic         exc_reg;
  logic [7:0]   exc_code_reg;
  logic         last_reg;
  logic         rx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  assign rx_take = RX_VALID && (state_reg == S_IDLE || state_reg == S_RECV);

  always_ff @(posedge CLK) begin
    if (rx_take && len_reg < rsfdc_pkg::LEN_BUF_MAX) begin
      buf_mem[len_reg[5:0]] <= RX_BYTE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N || state_reg == S_CHECK) begin
      len_reg    <= 8'h00;
      err_reg    <= 1'b0;
      rx_crc_reg <= rsfdc_pkg::CRC_INIT;
    end else if (rx_take) begin
      len_reg    <= (len_reg == 8'hff) ? len_reg : len_reg + 8'h01;
      err_reg    <= err_reg | RX_ERR;
      rx_crc_reg <= rsfdc_pkg::crc_byte(rx_crc_reg, RX_BYTE); // [R8] [R13]
    end
  end

  // Silence counter; only runs inside a frame so it never wraps
  always_ff @(posedge CLK) begin
    if (!RST_N || rx_take || state_reg != S_RECV) begin
      gap_reg <= 32'h0;
    end else begin
      gap_reg <= gap_reg + 32'h1; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame check and decode
  logic [7:0]  c_addr;
  logic [7:0]  c_func;
  logic [15:0] c_qty;
  logic [7:0]  c_bcnt;
  logic        c_bcast;
  logic        c_good;
  logic        c_supp;
  logic        c_bc_ok;
  logic        c_data_ok;

  always_comb begin
    c_addr    = buf_mem[0];
    c_func    = buf_mem[1];
    c_qty     = {buf_mem[4], buf_mem[5]};
    c_bcnt    = buf_mem[6];
    c_bcast   = (c_addr == rsfdc_pkg::BCAST_ADDR); // [R12]
    // Residue of zero means the trailing low/high CRC pair matched
    c_good    = (len_reg >= rsfdc_pkg::LEN_MIN) && !err_reg && (rx_crc_reg == 16'h0000)
                && (c_bcast || c_addr == STATION); // [R8] [R10]
    c_supp    = 1'b0;
    c_bc_ok   = 1'b0;
    c_data_ok = 1'b0;
    case (c_func)
      rsfdc_pkg::FC_READ: begin
        c_supp    = 1'b1; // [R1]
        c_data_ok = (len_reg == rsfdc_pkg::LEN_FIXED) && (c_qty != 16'h0)
                    && (c_qty <= rsfdc_pkg::MAX_READ_QTY); // [R6]
      end
      rsfdc_pkg::FC_WRITE1: begin
        c_supp    = 1'b1;
        c_bc_ok   = 1'b1; // [R2]
        c_data_ok = (len_reg == rsfdc_pkg::LEN_FIXED);
      end
      rsfdc_pkg::FC_DIAG: begin
        c_supp    = 1'b1; // [R3]
        c_data_ok = (len_reg == rsfdc_pkg::LEN_FIXED);
      end
      rsfdc_pkg::FC_WRITEN: begin
        c_supp    = 1'b1;
        c_bc_ok   = 1'b1; // [R4]
        c_data_ok = (len_reg <= rsfdc_pkg::LEN_BUF_MAX) && (c_qty != 16'h0)
                    && (c_qty[15:7] == 9'h0) && (c_bcnt == {c_qty[6:0], 1'b0})
                    && ({1'b0, len_reg} == rsfdc_pkg::LEN_MULTI_HDR + {1'b0, c_bcnt}); // [R6]
      end
      rsfdc_pkg::FC_LOG: begin
        c_supp    = 1'b1; // [R5]
        c_data_ok = (len_reg == rsfdc_pkg::LEN_LOG);
      end
      default: begin
        c_supp = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and transmit framing
  logic [7:0] tx_pick;

  always_comb begin
    case (state_reg)
      S_ADDR:  tx_pick = REQ.addr;
      S_FUNC:  tx_pick = exc_reg ? (REQ.func | rsfdc_pkg::EXC_FLAG) : REQ.func; // [R9]
      S_EXC:   tx_pick = exc_code_reg;
      S_CRCL:  tx_pick = tx_crc_reg[7:0]; // [R7]
      S_CRCH:  tx_pick = tx_crc_reg[15:8];
      default: tx_pick = TX_IN_BYTE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg    <= S_IDLE;
      REQ_VALID    <= 1'b0;
      REQ          <= '0;
      FRAME_DROP   <= 1'b0;
      exc_reg      <= 1'b0;
      exc_code_reg <= 8'h00;
      last_reg     <= 1'b0;
      tx_crc_reg   <= rsfdc_pkg::CRC_INIT;
      TX_VALID     <= 1'b0;
      TX_BYTE      <= 8'h00;
      TX_IN_READY  <= 1'b0;
    end else begin
      REQ_VALID   <= 1'b0;
      FRAME_DROP  <= 1'b0;
      TX_IN_READY <= (state_reg == S_BODY) && !TX_VALID && !(TX_IN_READY && TX_IN_VALID);
      case (state_reg)
        S_IDLE: begin
          if (rx_take) state_reg <= S_RECV;
        end
        S_RECV: begin
          if (!rx_take && gap_reg == 32'(GAP_CYCLES - 1)) state_reg <= S_CHECK; // [R11]
        end
        S_CHECK: begin
          tx_crc_reg   <= rsfdc_pkg::CRC_INIT;
          REQ          <= '{addr: c_addr, func: c_func, bcast: c_bcast,
                            reg_addr: {buf_mem[2], buf_mem[3]}, word: c_qty,
                            byte_cnt: (c_func == rsfdc_pkg::FC_WRITEN) ? c_bcnt : 8'h00};
          exc_reg      <= !c_supp || !c_data_ok;
          exc_code_reg <= c_supp ? rsfdc_pkg::ERR_ILL_DATA : rsfdc_pkg::ERR_ILL_FUNC;
          if (!c_good || (c_bcast && !(c_bc_ok && c_data_ok))) begin
            state_reg  <= S_IDLE; // [R10] [R14]
            FRAME_DROP <= 1'b1;
          end else if (c_bcast) begin
            state_reg <= S_IDLE; // [R12]
            REQ_VALID <= 1'b1;
          end else begin
            state_reg <= S_ADDR;
            REQ_VALID <= c_supp && c_data_ok;
          end
        end
        S_BODY: begin
          if (TX_IN_READY && TX_IN_VALID) begin
            TX_VALID   <= 1'b1;
            TX_BYTE    <= tx_pick;
            tx_crc_reg <= rsfdc_pkg::crc_byte(tx_crc_reg, tx_pick); // [R7]
            last_reg   <= TX_IN_LAST;
          end else if (TX_VALID && TX_READY) begin
            TX_VALID <= 1'b0;
            if (last_reg) state_reg <= S_CRCL;
          end
        end
        S_ADDR, S_FUNC, S_EXC, S_CRCL, S_CRCH: begin
          if (!TX_VALID) begin
            TX_VALID <= 1'b1;
            TX_BYTE  <= tx_pick;
            if (state_reg != S_CRCL && state_reg != S_CRCH) begin
              tx_crc_reg <= rsfdc_pkg::crc_byte(tx_crc_reg, tx_pick);
            end
          end else if (TX_READY) begin
            TX_VALID <= 1'b0;
            case (state_reg)
              S_ADDR:  state_reg <= S_FUNC;
              S_FUNC:  state_reg <= exc_reg ? S_EXC : S_BODY;
              S_EXC:   state_reg <= S_CRCL;
              S_CRCL:  state_reg <= S_CRCH; // [R7]
              default: state_reg <= S_IDLE;
            endcase
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data word read port for multi-register writes
  logic [6:0] rd_at;
  assign rd_at = rsfdc_pkg::MULTI_DATA_AT + {1'b0, DATA_IDX, 1'b0};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DATA_WORD <= 16'h0000;
    end else if (rd_at < 7'(rsfdc_pkg::BUF_DEPTH - 1)) begin
      DATA_WORD <= {buf_mem[rd_at[5:0]], buf_mem[rd_at[5:0] + 6'h01]}; // [R6]
    end else begin
      DATA_WORD <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_read_unicast: assert property (@(posedge CLK) disable iff (!RST_N) // [R1]
    REQ_VALID && REQ.func == rsfdc_pkg::FC_READ |-> !REQ.bcast)
    else $error("read request issued from broadcast");
  a_write1_bcast: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
    state_reg == S_CHECK && c_good && c_bcast && c_func == rsfdc_pkg::FC_WRITE1 && c_data_ok
    |=> REQ_VALID && REQ.bcast)
    else $error("broadcast single write not executed");
  a_diag_unicast: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    REQ_VALID && REQ.func == rsfdc_pkg::FC_DIAG |-> !REQ.bcast)
    else $error("diagnostic issued from broadcast");
  a_writen_bcast: assert property (@(posedge CLK) disable iff (!RST_N) // [R4]
    state_reg == S_CHECK && c_good && c_bcast && c_func == rsfdc_pkg::FC_WRITEN && c_data_ok
    |=> REQ_VALID && REQ.bcast)
    else $error("broadcast multi write not executed");
  a_log_unicast: assert property (@(posedge CLK) disable iff (!RST_N) // [R5]
    REQ_VALID && REQ.func == rsfdc_pkg::FC_LOG |-> !REQ.bcast)
    else $error("log read issued from broadcast");
  a_multi_layout: assert property (@(posedge CLK) disable iff (!RST_N) // [R6]
    REQ_VALID && REQ.func == rsfdc_pkg::FC_WRITEN |-> REQ.byte_cnt == {REQ.word[6:0], 1'b0})
    else $error("multi write byte count mismatch");
  a_crc_order: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    state_reg == S_CRCL && TX_VALID && TX_READY |=> state_reg == S_CRCH ##1
    TX_VALID && TX_BYTE == $past(tx_crc_reg[15:8]))
    else $error("crc high byte not after low byte");
  a_crc_drop: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    state_reg == S_CHECK && rx_crc_reg != 16'h0000 |=> state_reg == S_IDLE && FRAME_DROP)
    else $error("bad crc frame not dropped");
  a_exc_flag: assert property (@(posedge CLK) disable iff (!RST_N) // [R9]
    state_reg == S_FUNC && TX_VALID && exc_reg |-> TX_BYTE[7])
    else $error("exception reply without bit 7");
  a_err_silent: assert property (@(posedge CLK) disable iff (!RST_N) // [R10]
    state_reg == S_CHECK && err_reg |=> !TX_VALID [*4])
    else $error("reply sent after reception error");
  a_gap_end: assert property (@(posedge CLK) disable iff (!RST_N) // [R11]
    state_reg == S_RECV && !rx_take && gap_reg == 32'(GAP_CYCLES - 1) |=> state_reg == S_CHECK)
    else $error("frame end not seen after gap");
  a_bcast_quiet: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
    REQ_VALID && REQ.bcast |-> state_reg == S_IDLE && !TX_VALID && !TX_IN_READY)
    else $error("broadcast answered");
  a_bcast_forbid: assert property (@(posedge CLK) disable iff (!RST_N) // [R14]
    state_reg == S_CHECK && c_good && c_bcast && !c_bc_ok |=> !REQ_VALID && state_reg == S_IDLE)
    else $error("forbidden broadcast executed");
endmodule // rsfdc_slave
`default_nettype wire
